// ### rtl/asf_core.sv
// Purpose: Codes, saturates, packs and buffers converter samples for the host.
// Assumes: Converter delivers a raw code, twos complement in bipolar mode, plus range flags.
// Notes: Acquisition runs on through both errors; the error flags are sticky until cleared.
`timescale 1ns/100ps
`default_nettype none
module asf_core (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Configuration
   input wire logic i_bipolar,
   input wire logic i_res16,
   input wire logic i_run,
   // Converter side
   input wire logic i_sample_clk,
   input wire logic i_conv_busy,
   input wire logic i_conv_done,
   input wire logic [15:0] i_conv_code,
   input wire logic i_over_range,
   input wire logic i_under_range,
   // Host drain side
   input wire logic i_host_ready,
   output logic o_host_valid,
   output logic [15:0] o_host_data,
   // Firmware and errors
   output logic o_half_full_irq,
   output logic o_over_sample_err,
   output logic o_fifo_full_err,
   input wire logic i_clr_over_sample,
   input wire logic i_clr_fifo_full,
   // Front panel
   output logic o_led_green
);
   typedef enum logic [1:0] {ST_IDLE, ST_BLOCK, ST_WAIT} asf_xfer_type;

   asf_xfer_type state;
   logic [15:0] coded;
   logic [15:0] low_sample;
   logic odd_slot;
   logic pack_wr;
   logic [15:0] pack_data;
   logic fifo_rd;
   logic [15:0] fifo_rdata;
   logic [asf_pkg::CNT_W-1:0] fifo_count;
   logic [asf_pkg::CNT_W-1:0] block_left;
   logic [22:0] blink_cnt;
   logic blink;
   logic fifo_full;

   // The converter is trusted to hold its code and range flags for the done cycle only,
   // so the code is formed combinationally and registered by the packer in that cycle.
   // Over-range and under-range are decided upstream; this block only maps them to the
   // end codes, so a converter that raises both gets all ones.

   // Forms the output code: offset binary flips the sign bit of the signed reading.
   function automatic logic [15:0] asf_format(input logic [15:0] raw, input logic bip,
                                              input logic r16, input logic ovr,
                                              input logic unr);
      logic [15:0] v;
      v = r16 ? raw : (raw & asf_pkg::CODE_MAX12);
      if (bip) begin
         v = v ^ (r16 ? asf_pkg::BIPOLAR_FLIP16 : asf_pkg::BIPOLAR_FLIP12);
      end
      if (ovr) begin
         v = r16 ? asf_pkg::CODE_MAX16 : asf_pkg::CODE_MAX12;
      end else if (unr) begin
         v = asf_pkg::CODE_MIN;
      end
      return v;
   endfunction : asf_format

   // The step weight is fixed by span and width; only the bit width is chosen here.
   assign coded = asf_format(i_conv_code, i_bipolar, i_res16, i_over_range,
                             i_under_range);
   // Full is judged in words, because the buffer stores packed pairs.
   assign fifo_full = (fifo_count == asf_pkg::CNT_W'(asf_pkg::FIFO_DEPTH / 2));

   // Pairs samples into words, even slot low and odd slot high.
   // Stopping acquisition resets the pairing, so the first sample of a run is always even.
   // A sample left over without a partner when the run stops is dropped on purpose:
   // a half-filled word would shift every later pair by one byte.
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         odd_slot <= 1'b0;
         low_sample <= 16'h0000;
         pack_wr <= 1'b0;
         pack_data <= 16'h0000;
      end else begin
         pack_wr <= 1'b0;
         if (!i_run) begin
            odd_slot <= 1'b0;
         end else if (i_conv_done) begin
            if (!odd_slot) begin
               low_sample <= coded;
               odd_slot <= 1'b1;
            end else begin
               pack_data <= {coded[7:0], low_sample[7:0]};
               pack_wr <= 1'b1;
               odd_slot <= 1'b0;
            end
         end
      end
   end

   asf_fifo u_fifo (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_wr(pack_wr),
      .i_wdata(pack_data),
      .i_rd(fifo_rd),
      .o_rdata(fifo_rdata),
      .o_count(fifo_count)
   );

   // Half-full signal toward firmware.
   // It is a level, not a pulse, so firmware that is busy cannot miss it; it drops as
   // soon as the mover has taken the buffer back below half.
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_half_full_irq <= 1'b0;
      end else begin
         o_half_full_irq <= i_run && (fifo_count >= asf_pkg::HALF_FULL);
      end
   end

   // Block mover: after half full, streams one block out to the host buffer.
   // The block is longer than what is buffered at the signal, so the mover keeps
   // reading as new words arrive until the whole block has gone out.
   // Reads wait while the output word is still held for a slow host.
   assign fifo_rd = (state == ST_BLOCK) && (!o_host_valid || i_host_ready)
                    && (fifo_count != '0) && (block_left != '0);

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= ST_IDLE;
         block_left <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (o_half_full_irq) begin
                  block_left <= asf_pkg::BLOCK_WORDS;
                  state <= ST_BLOCK;
               end
            end
            ST_BLOCK: begin
               if (fifo_rd) begin
                  block_left <= block_left - 1'b1;
               end
               if (block_left == '0) begin
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (!o_host_valid) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_host_valid <= 1'b0;
         o_host_data <= 16'h0000;
      end else begin
         if (fifo_rd) begin
            o_host_valid <= 1'b1;
            o_host_data <= fifo_rdata;
         end else if (i_host_ready) begin
            o_host_valid <= 1'b0;
         end
      end
   end

   // Sticky error flags; a new event in the clearing cycle wins over the clear.
   // Neither flag stops the packer or the mover: data keeps flowing while it is set.
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_over_sample_err <= 1'b0;
      end else if (i_sample_clk && i_conv_busy) begin
         o_over_sample_err <= 1'b1;
      end else if (i_clr_over_sample) begin
         o_over_sample_err <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_fifo_full_err <= 1'b0;
      end else if (pack_wr && fifo_full) begin
         o_fifo_full_err <= 1'b1;
      end else if (i_clr_fifo_full) begin
         o_fifo_full_err <= 1'b0;
      end
   end

   // Status blink, about one toggle each half second.
   // The counter runs free so the light resumes in step once the errors are cleared.
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         blink_cnt <= 23'h000000;
         blink <= 1'b0;
      end else if (blink_cnt == '0) begin
         blink_cnt <= asf_pkg::BLINK_RELOAD;
         blink <= ~blink;
      end else begin
         blink_cnt <= blink_cnt - 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_led_green <= 1'b0;
      end else begin
         o_led_green <= blink && !o_over_sample_err && !o_fifo_full_err;
      end
   end
endmodule : asf_core
`default_nettype wire

// ### rtl/asf_fifo.sv
// Purpose: Flip-flop FIFO for packed transfer words.
// Assumes: Writes are dropped when full.
// Notes: Count is exact so half full and full are honest.
`timescale 1ns/100ps
`default_nettype none
module asf_fifo (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Fill side
   input wire logic i_wr,
   input wire logic [15:0] i_wdata,
   // Drain side
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   output logic [asf_pkg::CNT_W-1:0] o_count
);
   logic [15:0] mem [asf_pkg::FIFO_DEPTH/2];
   logic [asf_pkg::PTR_W-2:0] wptr;
   logic [asf_pkg::PTR_W-2:0] rptr;
   logic do_wr;
   logic do_rd;

   // Depth counts samples; each word holds two of them.
   assign do_wr = i_wr && (o_count != asf_pkg::CNT_W'(asf_pkg::FIFO_DEPTH / 2));
   assign do_rd = i_rd && (o_count != '0);
   assign o_rdata = mem[rptr];

   always_ff @(posedge i_sys_clk) begin
      if (do_wr) begin
         mem[wptr] <= i_wdata;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wptr <= '0;
         rptr <= '0;
         o_count <= '0;
      end else begin
         if (do_wr) begin
            wptr <= wptr + 1'b1;
         end
         if (do_rd) begin
            rptr <= rptr + 1'b1;
         end
         o_count <= o_count + asf_pkg::CNT_W'(do_wr) - asf_pkg::CNT_W'(do_rd);
      end
   end
endmodule : asf_fifo
`default_nettype wire

// ### rtl/asf_pkg.sv
// Purpose: Shared constants for the sample format and transfer block.
// Assumes: One 10 MHz module clock.
// Notes: Sample width is 16 bits; 12-bit samples sit in the low bits.
package asf_pkg;
   localparam int SAMPLE_W = 16;
   localparam int RES_LO = 12;
   localparam int FIFO_DEPTH = 2048;
   localparam int PTR_W = 11;
   localparam int CNT_W = 12;
   // Counts are in words of two samples: 512 words are 1024 samples, half of the 2048.
   localparam logic [CNT_W-1:0] HALF_FULL = 12'h200;
   // One moved block is 2048 samples, which is 1024 words.
   localparam logic [CNT_W-1:0] BLOCK_WORDS = 12'h400;
   localparam logic [15:0] CODE_MAX16 = 16'hFFFF;
   localparam logic [15:0] CODE_MAX12 = 16'h0FFF;
   localparam logic [15:0] CODE_MIN = 16'h0000;
   localparam logic [15:0] BIPOLAR_FLIP16 = 16'h8000;
   localparam logic [15:0] BIPOLAR_FLIP12 = 16'h0800;
   localparam int FULL_SCALE_SPAN_UNI = 10;
   localparam int FULL_SCALE_SPAN_BI = 20;
   localparam int CLK_HZ = 10_000_000;
   localparam real BLINK_S = 0.5;
   localparam int BLINK_CYCLES = int'(BLINK_S * CLK_HZ);
   localparam logic [22:0] BLINK_RELOAD = 23'(BLINK_CYCLES - 1);
endpackage : asf_pkg

// ### test/asf_core_properties.sv
// Purpose: Port-level checks for asf_core.
// Assumes: One clock; reset is active low.
// Notes: Bound into every asf_core instance.
`timescale 1ns/100ps
`default_nettype none
module asf_core_checker (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Watched ports
   input wire logic i_run,
   input wire logic i_sample_clk,
   input wire logic i_conv_busy,
   input wire logic i_host_ready,
   input wire logic o_host_valid,
   input wire logic [15:0] o_host_data,
   input wire logic o_half_full_irq,
   input wire logic o_over_sample_err,
   input wire logic o_fifo_full_err,
   input wire logic i_clr_over_sample,
   input wire logic i_clr_fifo_full,
   input wire logic o_led_green
);
   logic ovs_req;
   logic any_err;
   assign ovs_req = i_sample_clk && i_conv_busy;
   assign any_err = o_over_sample_err || o_fifo_full_err;
   default clocking @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);
   ovs_set_a: assert property (ovs_req |-> ##[1:2] o_over_sample_err)
      else $error("over-sample error not raised");
   ovs_hold_a: assert property (o_over_sample_err && !i_clr_over_sample |=> o_over_sample_err)
      else $error("over-sample error dropped");
   ovs_clear_a: assert property (i_clr_over_sample && !ovs_req && !$past(ovs_req)
      |=> ##[0:1] !o_over_sample_err)
      else $error("over-sample error not cleared");
   full_hold_a: assert property (o_fifo_full_err && !i_clr_fifo_full |=> o_fifo_full_err)
      else $error("fifo full error dropped");
   full_cause_a: assert property ($rose(o_fifo_full_err) |-> o_half_full_irq)
      else $error("fifo full error without a full buffer");
   led_err_a: assert property (any_err && $past(any_err) |-> !o_led_green)
      else $error("status light blinks during an error");
   valid_hold_a: assert property (o_host_valid && !i_host_ready
      |=> o_host_valid && $stable(o_host_data))
      else $error("host word changed before it was taken");
   irq_run_a: assert property (!i_run |=> !o_half_full_irq)
      else $error("half full signal while stopped");
   irq_move_a: assert property ($rose(o_half_full_irq) |-> ##[0:4] o_host_valid)
      else $error("block move did not start");
endmodule : asf_core_checker
bind asf_core asf_core_checker asf_core_checker_i (.*);
`default_nettype wire

// ### test/asf_core_tb.sv
// Purpose: Self-checking bench for asf_core.
// Assumes: Inputs change on the falling edge.
// Notes: Only the low byte of each code is visible in a word.
`timescale 1ns/100ps
`default_nettype none
module asf_core_tb;
   logic clk = 1'b0, rst_n = 1'b0, bip = 1'b0, r16 = 1'b0, run = 1'b0;
   logic sclk = 1'b0, busy = 1'b0, done = 1'b0, ovr = 1'b0, unr = 1'b0;
   logic clr_o = 1'b0, clr_f = 1'b0, stall = 1'b1, chk = 1'b0, irq_seen = 1'b0;
   logic [15:0] code = 16'h0000;
   logic [15:0] expq[$];
   wire logic rdy, vld, irq, ovs, ffl, led;
   wire logic [15:0] data;
   int fail_count = 0, n_tests = 0, taken = 0;
   always #50 clk = ~clk;
   asf_core asf_core_i (.i_sys_clk(clk), .i_rst_n(rst_n), .i_bipolar(bip), .i_res16(r16),
      .i_run(run), .i_sample_clk(sclk), .i_conv_busy(busy), .i_conv_done(done),
      .i_conv_code(code), .i_over_range(ovr), .i_under_range(unr), .i_host_ready(rdy),
      .o_host_valid(vld), .o_host_data(data), .o_half_full_irq(irq),
      .o_over_sample_err(ovs), .o_fifo_full_err(ffl), .i_clr_over_sample(clr_o),
      .i_clr_fifo_full(clr_f), .o_led_green(led));
   asf_host_model asf_host_model_i (.i_sys_clk(clk), .i_rst_n(rst_n), .i_stall(stall),
      .o_ready(rdy));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic logic [15:0] raw(input int k);
      return {k[7:0], k[7:0] ^ 8'h5A};
   endfunction : raw
   function automatic logic [15:0] cod(input int k);
      logic [15:0] m;
      m = k[10] ? asf_pkg::CODE_MAX16 : asf_pkg::CODE_MAX12;
      if (k % 7 == 3) return m;
      if (k % 5 == 1) return asf_pkg::CODE_MIN;
      return (raw(k) ^ (k[9] ? (k[10] ? 16'h8000 : 16'h0800) : 16'h0000)) & m;
   endfunction : cod
   task automatic put(input int k);
      @(negedge clk);
      code = raw(k);
      ovr = (k % 7 == 3);
      unr = (k % 5 == 1);
      bip = k[9];
      r16 = k[10];
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
   endtask : put
   task automatic fill(input int n, input int base);
      logic [15:0] e, o;
      for (int j = base; j < base + 2 * n; j += 2) begin
         put(j);
         put(j + 1);
         e = cod(j);
         o = cod(j + 1);
         expq.push_back({o[7:0], e[7:0]});
      end
   endtask : fill
   // Words are judged half a cycle before the edge that takes them.
   always @(negedge clk) begin
      if (irq) irq_seen = 1'b1;
      if (chk && vld && rdy) begin
         taken++;
         if (expq.size() > 0) check("host word", data, expq.pop_front());
      end
   end
   task automatic scen_stream;
      stall = 1'b0;
      chk = 1'b1;
      sclk = 1'b1;
      @(negedge clk) sclk = 1'b0;
      repeat (2) @(negedge clk);
      check("idle over-sample", 16'(ovs), 16'h0000);
      fill(512, 0);
      {sclk, busy} = 2'b11;
      @(negedge clk) {sclk, busy} = 2'b00;
      repeat (2) @(negedge clk);
      check("over-sample set", 16'(ovs), 16'h0001);
      check("light off", 16'(led), 16'h0000);
      fill(512, 1024);
      for (int t = 0; t < 4000 && taken < 1024; t++) @(negedge clk);
      check("words moved", 16'(taken), 16'h0400);
      check("half full seen", 16'(irq_seen), 16'h0001);
      clr_o = 1'b1;
      @(negedge clk) clr_o = 1'b0;
      repeat (2) @(negedge clk);
      check("over-sample cleared", 16'(ovs), 16'h0000);
   endtask : scen_stream
   task automatic scen_full;
      rst_n = 1'b0;
      chk = 1'b0;
      stall = 1'b1;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      check("errors after reset", {14'h0, ovs, ffl}, 16'h0000);
      fill(511, 0);
      check("below half", 16'(irq), 16'h0000);
      fill(1, 1022);
      repeat (2) @(negedge clk);
      check("at half", 16'(irq), 16'h0001);
      fill(515, 1024);
      repeat (2) @(negedge clk);
      check("full flag", 16'(ffl), 16'h0001);
      check("half full", 16'(irq), 16'h0001);
      clr_f = 1'b1;
      @(negedge clk) clr_f = 1'b0;
      repeat (2) @(negedge clk);
      check("full cleared", 16'(ffl), 16'h0000);
      run = 1'b0;
      repeat (2) @(negedge clk);
      check("half full stopped", 16'(irq), 16'h0000);
   endtask : scen_full
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out
   initial begin
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      run = 1'b1;
      scen_stream();
      scen_full();
      close_out();
   end
   initial begin
      repeat (30000) @(posedge clk);
      fail_count++;
      close_out();
   end
endmodule : asf_core_tb
`default_nettype wire

// ### test/asf_host_model.sv
// Purpose: Host side that drains packed words.
// Assumes: Stall input holds the host off entirely.
// Notes: Ready also drops one cycle in four.
`timescale 1ns/100ps
`default_nettype none
module asf_host_model (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Bench control
   input wire logic i_stall,
   // Handshake
   output logic o_ready
);
   logic [1:0] phase;
   // A periodic gap makes words wait on a slow host too.
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         phase <= 2'h0;
         o_ready <= 1'b0;
      end else begin
         phase <= phase + 2'h1;
         o_ready <= !i_stall && (phase != 2'h3);
      end
   end
endmodule : asf_host_model
`default_nettype wire
